// [bench/ssw_host_model.sv]
`default_nettype none

// host side: waits after each reset, then kicks the watchdog; can press either reset pin
module ssw_host_model #(
    parameter int BOOT_CYC = 16  // settle time after reset goes away, kept short
) (
    // clock and bench reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // control from the bench
    input  wire logic       kick_en,      // host software alive
    input  wire logic [7:0] kick_gap,     // cycles between kicks
    // resolved reset wires
    input  wire logic       rst_hi_pin,
    input  wire logic       rst_lo_n_pin,
    // host drives
    output logic            watchdog_kick_input,
    output logic            host_hi_drive,  // pulls active-high pin up
    output logic            host_lo_drive   // pulls active-low pin down
);
    timeunit 1ns;
    timeprecision 1ps;

    int boot_cnt;  // cycles since both reset wires went inactive
    int gap_cnt;   // cycles since the last kick

    initial begin
        watchdog_kick_input = 1'b0;
        host_hi_drive       = 1'b0;
        host_lo_drive       = 1'b0;
    end

    // kicker: a host held in reset runs no code, so it restarts its boot wait;
    // its own press only counts once the supervisor takes the line over, else
    // a train of short presses would starve the watchdog
    always @(negedge clk_sys) begin
        if (!rst_n || (rst_hi_pin && !host_hi_drive) || (!rst_lo_n_pin && !host_lo_drive)) begin
            boot_cnt = 0;
            gap_cnt  = 0;
        end else if (boot_cnt < BOOT_CYC) begin
            boot_cnt++;
        end else if (kick_en) begin
            gap_cnt++;
            if (gap_cnt >= int'(kick_gap)) begin
                watchdog_kick_input = ~watchdog_kick_input;
                gap_cnt             = 0;
            end
        end
    end

    // push button: called at a falling edge, holds the pin for width cycles
    task automatic press(input logic on_hi, input int width);
        if (on_hi) begin
            host_hi_drive = 1'b1;
        end else begin
            host_lo_drive = 1'b1;
        end
        repeat (width) @(negedge clk_sys);
        host_hi_drive = 1'b0;
        host_lo_drive = 1'b0;
    endtask : press

endmodule : ssw_host_model

`default_nettype wire

// [bench/ssw_top_tb_top.sv]
`default_nettype none

module ssw_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // shortened counts and bench state
    // ------------------------------------------------------------
    localparam int W = 200;      // watchdog period in cycles
    localparam int R = 50;       // reset timeout in cycles
    localparam int P = 30;       // program cycle in cycles
    localparam int LIMIT = 4000; // hang ceiling, run needs about 2000
    typedef struct {logic val; int lo; int hi;} ssw_note_t;  // expected edge and window
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        supply_low = 1'b1;
    logic        write_protect = 1'b0;
    logic        write_stop = 1'b0;
    logic        kick_en = 1'b0;
    logic [7:0]  kick_gap = 8'h30;
    logic        watchdog_kick_input, host_hi_drive, host_lo_drive;
    logic        rst_hi_out, rst_hi_oe, rst_lo_n_out, rst_lo_n_oe, rst_hi_pin, rst_lo_n_pin;
    logic        bus_enable, data_ack_enable, array_write_enable, prog_busy;
    logic [2:0]  mem_gates;      // bus, data ack and array write enables together
    logic [31:0] rng = 32'h24;   // xorshift state
    logic        prev_oe = 1'b1; // reset drives the pins
    logic        prev_busy = 1'b0;
    int          n_errors = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          c;
    ssw_note_t   q_rst[$];       // expected reset pin edges
    ssw_note_t   q_busy[$];      // expected program cycle edges

    // open-drain wires: hi pin pulled down, lo pin pulled up
    assign rst_hi_pin   = (rst_hi_oe & rst_hi_out) | host_hi_drive;
    assign rst_lo_n_pin = ~((rst_lo_n_oe & ~rst_lo_n_out) | host_lo_drive);
    assign mem_gates    = {bus_enable, data_ack_enable, array_write_enable};

    always #5 clk_sys = ~clk_sys;

    ssw_top #(.WDOG_CYC(32'(W)), .RST_CYC(32'(R)), .PROG_CYC(32'(P))) i_ssw_top (
        .clk_sys(clk_sys), .rst_n(rst_n), .supply_low(supply_low),
        .watchdog_kick_input(watchdog_kick_input), .write_protect(write_protect),
        .rst_hi_in(rst_hi_pin), .rst_hi_out(rst_hi_out), .rst_hi_oe(rst_hi_oe),
        .rst_lo_n_in(rst_lo_n_pin), .rst_lo_n_out(rst_lo_n_out), .rst_lo_n_oe(rst_lo_n_oe),
        .write_stop(write_stop), .bus_enable(bus_enable), .data_ack_enable(data_ack_enable),
        .array_write_enable(array_write_enable), .prog_busy(prog_busy));

    ssw_host_model i_ssw_host_model (
        .clk_sys(clk_sys), .rst_n(rst_n), .kick_en(kick_en), .kick_gap(kick_gap),
        .rst_hi_pin(rst_hi_pin), .rst_lo_n_pin(rst_lo_n_pin),
        .watchdog_kick_input(watchdog_kick_input), .host_hi_drive(host_hi_drive),
        .host_lo_drive(host_lo_drive));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            n_errors++;
        end
    endtask : chk

    // an edge with no note waiting is wrong too
    task automatic chk_evt(input string name, ref ssw_note_t q[$], input logic got);
        ssw_note_t n;
        cmp_count++;
        n = '{1'bx, 0, -1};
        if (q.size() != 0) begin
            n = q.pop_front();
        end
        if (got !== n.val || cyc < n.lo || cyc > n.hi) begin
            $display("MISMATCH %s expected %b in %0d..%0d seen %b at %0d",
                     name, n.val, n.lo, n.hi, got, cyc);
            n_errors++;
        end
    endtask : chk_evt

    task automatic note(input logic to_rst, input logic v, input int lo, input int hi);
        if (to_rst) begin
            q_rst.push_back('{v, lo, hi});
        end else begin
            q_busy.push_back('{v, lo, hi});
        end
    endtask : note

    task automatic final_report();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    // ------------------------------------------------------------
    // cycle count, hang guard and output watcher
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_errors++;
            final_report();
        end
    end

    // sampled at the falling edge, where registered outputs have settled
    always @(negedge clk_sys) begin
        if (rst_n) begin
            if (rst_hi_oe !== prev_oe) chk_evt("rst_hi_oe", q_rst, rst_hi_oe);
            if (prog_busy !== prev_busy) chk_evt("prog_busy", q_busy, prog_busy);
            chk("rst_lo_n_oe", 32'(rst_hi_oe), 32'(rst_lo_n_oe));
            if (rst_hi_oe === 1'b1) begin
                chk("gates_in_reset", 32'h0, 32'({mem_gates, ~rst_hi_out, rst_lo_n_out}));
            end
            if (prog_busy === 1'b1) chk("bus_while_busy", 32'h0, 32'(bus_enable));
        end
        prev_oe   = rst_hi_oe;
        prev_busy = prog_busy;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(negedge clk_sys);
        rst_n = 1'b1;
        // supply comes good; no kicks, so the watchdog fires twice in a row
        repeat (20) @(negedge clk_sys);
        c = cyc;
        note(1'b1, 1'b0, c + R, c + R + 8);
        note(1'b1, 1'b1, c + R + W - 2, c + R + W + 10);
        note(1'b1, 1'b0, c + 2 * R + W - 2, c + 2 * R + W + 12);
        note(1'b1, 1'b1, c + 2 * R + 2 * W - 4, c + 2 * R + 2 * W + 14);
        note(1'b1, 1'b0, c + 3 * R + 2 * W - 4, c + 3 * R + 2 * W + 16);
        supply_low = 1'b0;
        repeat (2 * R + 2 * W + 20) @(negedge clk_sys);
        // kicks at random gaps keep the watchdog quiet
        kick_en = 1'b1;
        repeat (12) begin
            rng      = xs(rng);
            kick_gap = 8'(20 + rng % 60);
            repeat (60) @(negedge clk_sys);
        end
        // manual press on the low pin, then the high pin
        for (int p = 0; p < 2; p++) begin
            c = cyc;
            note(1'b1, 1'b1, c + 11, c + 20);
            note(1'b1, 1'b0, c + R + 11, c + R + 22);
            i_ssw_host_model.press(p[0], 20);
            repeat (R + 40) @(negedge clk_sys);
        end
        // short pulses, the widest rejected one first, must not start a reset
        for (int g = 0; g < 6; g++) begin
            rng = xs(rng);
            i_ssw_host_model.press(rng[0], (g == 0) ? 10 : 1 + int'(rng % 10));
            repeat (40) @(negedge clk_sys);
        end
        // brownout and recovery
        c = cyc;
        note(1'b1, 1'b1, c + 1, c + 7);
        supply_low = 1'b1;
        repeat (30) @(negedge clk_sys);
        c = cyc;
        note(1'b1, 1'b0, c + R, c + R + 8);
        supply_low = 1'b0;
        repeat (R + 40) @(negedge clk_sys);
        // protected: address still answered, data and programming refused
        write_protect = 1'b1;
        repeat (8) @(negedge clk_sys);
        chk("protect_gates", 32'h4, 32'(mem_gates));
        write_stop = 1'b1;
        @(negedge clk_sys);
        write_stop = 1'b0;
        write_protect = 1'b0;
        repeat (8) @(negedge clk_sys);
        chk("write_open", 32'h7, 32'(mem_gates));
        // two program cycles back to back once the bus returns
        for (int k = 0; k < 2; k++) begin
            c = cyc;
            note(1'b0, 1'b1, c + 1, c + 2);
            note(1'b0, 1'b0, c + P + 1, c + P + 3);
            write_stop = 1'b1;
            @(negedge clk_sys);
            write_stop = 1'b0;
            repeat (P + 10) @(negedge clk_sys);
        end
        chk("pending_notes", 32'h0, 32'(q_rst.size() + q_busy.size()));
        final_report();
    end

endmodule : ssw_top_tb_top

`default_nettype wire

// [common/ssw_pkg.sv]
`default_nettype none

package ssw_pkg;

    // ------------------------------------------------------------
    // clock
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 100_000_000;  // system clock rate
    localparam int unsigned CLK_NS = 10;           // system clock period

    // ------------------------------------------------------------
    // printed times, each in its own unit
    // ------------------------------------------------------------
    localparam int unsigned WDOG_PERIOD_MS      = 1600;  // watchdog period, 1.6 s
    localparam int unsigned RST_TIMEOUT_MS      = 200;   // power_up_reset_timeout nominal
    localparam int unsigned PROG_MAX_MS         = 10;    // internal program cycle, longest
    localparam int unsigned GLITCH_NS           = 100;   // widest rejected reset pulse
    localparam int unsigned TRIP_DELAY_US       = 5;     // trip_to_reset_delay, longest
    localparam int unsigned POWER_UP_RD_DELAY_MS = 1;    // power_up_read_delay, host side
    localparam int unsigned POWER_UP_WR_DELAY_MS = 1;    // power_up_write_delay, host side

    // ------------------------------------------------------------
    // derived cycle counts
    // ------------------------------------------------------------
    localparam int unsigned CNT_W = 32;  // width of all long counters
    localparam logic [31:0] WDOG_CYC = 32'(WDOG_PERIOD_MS * (CLK_HZ / 1000));
    localparam logic [31:0] RST_CYC  = 32'(RST_TIMEOUT_MS * (CLK_HZ / 1000));
    localparam logic [31:0] PROG_CYC = 32'(PROG_MAX_MS * (CLK_HZ / 1000));
    localparam logic [3:0]  GLITCH_CYC = 4'(GLITCH_NS / CLK_NS);
    localparam logic [31:0] TRIP_CYC = 32'(TRIP_DELAY_US * (CLK_HZ / 1000000));

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic RST_SUPPLY_LOW = 1'b1;  // assume supply low until seen good
    localparam logic RST_KICK       = 1'b0;
    localparam logic RST_WP         = 1'b0;  // unconnected pin reads low
    localparam logic RST_HI_PIN     = 1'b0;  // active-high pin idles low
    localparam logic RST_LO_PIN     = 1'b1;  // active-low pin idles high

    // reset sequencer states
    typedef enum logic [1:0] {
        SSW_RUN,      // outputs released, watchdog counting
        SSW_HOLD,     // supply below trip level
        SSW_TIMEOUT   // driving reset, timing out
    } ssw_state_t;

endpackage : ssw_pkg

`default_nettype wire

// [design/ssw_sync.sv]
`default_nettype none

// three-stage synchroniser; the level moves once stages two and three agree
module ssw_sync #(
    parameter logic RST_VAL = 1'b0  // level held after reset
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // asynchronous pin and its clean level
    input  wire logic d_async,
    output logic      q_level
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic s1;   // metastable stage, read only by s2
        logic s2;
        logic s3;
        logic lvl;  // agreed level
    } ssw_sync_t;

    ssw_sync_t cur_q;  // registered state
    ssw_sync_t nxt_d;  // next state

    // next state: shift, accept when the last two agree
    always_comb begin
        nxt_d    = cur_q;
        nxt_d.s1 = d_async;
        nxt_d.s2 = cur_q.s1;
        nxt_d.s3 = cur_q.s2;
        if (cur_q.s2 == cur_q.s3) begin
            nxt_d.lvl = cur_q.s3;
        end
    end

    // register, synchronous reset to constants
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cur_q <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, lvl: RST_VAL};
        end else begin
            cur_q <= nxt_d;
        end
    end

    assign q_level = cur_q.lvl;

endmodule : ssw_sync

`default_nettype wire

// [design/ssw_top.sv]
`default_nettype none

module ssw_top #(
    parameter logic [31:0] WDOG_CYC = ssw_pkg::WDOG_CYC,  // watchdog period in cycles
    parameter logic [31:0] RST_CYC  = ssw_pkg::RST_CYC,   // reset timeout in cycles
    parameter logic [31:0] PROG_CYC = ssw_pkg::PROG_CYC   // program cycle in cycles
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // supervisor pins
    input  wire logic supply_low,            // comparator: supply below trip level
    input  wire logic watchdog_kick_input,   // host toggles this
    input  wire logic write_protect,         // high: array read-only
    // active-high reset pin, open drain
    input  wire logic rst_hi_in,
    output logic      rst_hi_out,
    output logic      rst_hi_oe,
    // active-low reset pin, open drain
    input  wire logic rst_lo_n_in,
    output logic      rst_lo_n_out,
    output logic      rst_lo_n_oe,
    // memory bus engine, same clock
    input  wire logic write_stop,            // pulse: valid stop ending a write
    output logic      bus_enable,            // may answer slave address
    output logic      data_ack_enable,       // may acknowledge write data
    output logic      array_write_enable,    // may program the array
    output logic      prog_busy              // internal program cycle running
);

    // ------------------------------------------------------------
    // synchronised pins
    // ------------------------------------------------------------
    logic low_s;   // supply low, clean level
    logic kick_s;  // watchdog kick, clean level
    logic wp_s;    // write protect, clean level
    logic hi_s;    // active-high reset pin, clean level
    logic lo_s;    // active-low reset pin, clean level

    ssw_sync #(.RST_VAL(ssw_pkg::RST_SUPPLY_LOW)) u_sync_low (
        .clk_sys(clk_sys), .rst_n(rst_n), .d_async(supply_low), .q_level(low_s));
    ssw_sync #(.RST_VAL(ssw_pkg::RST_KICK)) u_sync_kick (
        .clk_sys(clk_sys), .rst_n(rst_n), .d_async(watchdog_kick_input), .q_level(kick_s));
    ssw_sync #(.RST_VAL(ssw_pkg::RST_WP)) u_sync_wp (
        .clk_sys(clk_sys), .rst_n(rst_n), .d_async(write_protect), .q_level(wp_s));
    ssw_sync #(.RST_VAL(ssw_pkg::RST_HI_PIN)) u_sync_hi (
        .clk_sys(clk_sys), .rst_n(rst_n), .d_async(rst_hi_in), .q_level(hi_s));
    ssw_sync #(.RST_VAL(ssw_pkg::RST_LO_PIN)) u_sync_lo (
        .clk_sys(clk_sys), .rst_n(rst_n), .d_async(rst_lo_n_in), .q_level(lo_s));

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        ssw_pkg::ssw_state_t state;  // reset sequencer
        logic [31:0] rst_cnt;        // reset timeout counter
        logic [31:0] wdog_cnt;       // watchdog counter
        logic [31:0] prog_cnt;       // program cycle counter
        logic [3:0]  hi_gcnt;        // glitch filter run, high pin
        logic [3:0]  lo_gcnt;        // glitch filter run, low pin
        logic        hi_flt;         // filtered high pin
        logic        lo_flt;         // filtered low pin
        logic        kick_q;         // kick level one cycle back
        logic        drive;          // driving both reset pins
        logic        hi_level;       // value driven on high pin
        logic        lo_level;       // value driven on low pin
        logic        bus_en;
        logic        data_ack_en;
        logic        array_wr_en;
        logic        busy;
    } ssw_top_t;

    ssw_top_t cur_q;  // registered state
    ssw_top_t nxt_d;  // next state

    logic kick_edge;   // either edge on the kick level
    logic hi_rise;     // filtered rise of active-high pin
    logic lo_fall;     // filtered fall of active-low pin
    logic wdog_expire; // watchdog reached its period

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_d  = cur_q;
        // glitch filters: level moves only after more than 100 ns stable
        if (hi_s == cur_q.hi_flt) begin
            nxt_d.hi_gcnt = 4'h0;
        end else if (cur_q.hi_gcnt == ssw_pkg::GLITCH_CYC) begin
            nxt_d.hi_flt  = hi_s;
            nxt_d.hi_gcnt = 4'h0;
        end else begin
            nxt_d.hi_gcnt = cur_q.hi_gcnt + 4'h1;
        end
        if (lo_s == cur_q.lo_flt) begin
            nxt_d.lo_gcnt = 4'h0;
        end else if (cur_q.lo_gcnt == ssw_pkg::GLITCH_CYC) begin
            nxt_d.lo_flt  = lo_s;
            nxt_d.lo_gcnt = 4'h0;
        end else begin
            nxt_d.lo_gcnt = cur_q.lo_gcnt + 4'h1;
        end
        // edges seen while we drive are our own, so they are ignored
        hi_rise = !cur_q.hi_flt && nxt_d.hi_flt && !cur_q.drive;
        lo_fall = cur_q.lo_flt && !nxt_d.lo_flt && !cur_q.drive;
        nxt_d.kick_q = kick_s;
        kick_edge    = kick_s != cur_q.kick_q;
        wdog_expire  = cur_q.wdog_cnt == WDOG_CYC - 32'h1;
        // reset sequencer; supply low wins over every other cause
        if (low_s) begin
            nxt_d.state   = ssw_pkg::SSW_HOLD;
            nxt_d.rst_cnt = '0;
        end else begin
            case (cur_q.state)
                ssw_pkg::SSW_HOLD: begin
                    nxt_d.state   = ssw_pkg::SSW_TIMEOUT;
                    nxt_d.rst_cnt = '0;
                end
                ssw_pkg::SSW_TIMEOUT: begin
                    if (cur_q.rst_cnt == RST_CYC - 32'h1) begin
                        nxt_d.state = ssw_pkg::SSW_RUN;
                    end else begin
                        nxt_d.rst_cnt = cur_q.rst_cnt + 32'h1;
                    end
                end
                default: begin
                    // manual reset or expiry: same timeout as power-up
                    if (hi_rise || lo_fall || (wdog_expire && !kick_edge)) begin
                        nxt_d.state   = ssw_pkg::SSW_TIMEOUT;
                        nxt_d.rst_cnt = '0;
                    end
                end
            endcase
        end
        nxt_d.drive    = nxt_d.state != ssw_pkg::SSW_RUN;
        nxt_d.hi_level = nxt_d.drive;
        nxt_d.lo_level = !nxt_d.drive;
        // watchdog: frozen at zero while reset is asserted
        if (nxt_d.drive || cur_q.drive || kick_edge) begin
            nxt_d.wdog_cnt = '0;
        end else begin
            nxt_d.wdog_cnt = cur_q.wdog_cnt + 32'h1;
        end
        // program cycle; keeps running through a reset so the array finishes
        if (cur_q.busy) begin
            if (cur_q.prog_cnt == PROG_CYC - 32'h1) begin
                nxt_d.busy = 1'b0;
            end else begin
                nxt_d.prog_cnt = cur_q.prog_cnt + 32'h1;
            end
        end else if (write_stop && cur_q.array_wr_en) begin
            nxt_d.busy     = 1'b1;
            nxt_d.prog_cnt = '0;
        end
        // memory gating
        nxt_d.bus_en      = !nxt_d.drive && !nxt_d.busy;
        nxt_d.data_ack_en = nxt_d.bus_en && !wp_s;
        nxt_d.array_wr_en = nxt_d.data_ack_en && !low_s;
    end

    // ------------------------------------------------------------
    // register; reset drives the reset pins as at power-up
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cur_q          <= '0;
            cur_q.state    <= ssw_pkg::SSW_HOLD;
            cur_q.lo_flt   <= ssw_pkg::RST_LO_PIN;
            cur_q.hi_flt   <= ssw_pkg::RST_HI_PIN;
            cur_q.kick_q   <= ssw_pkg::RST_KICK;
            cur_q.drive    <= 1'b1;
            cur_q.hi_level <= 1'b1;
        end else begin
            cur_q <= nxt_d;
        end
    end

    // ------------------------------------------------------------
    // outputs, straight from the state register
    // ------------------------------------------------------------
    assign rst_hi_oe          = cur_q.drive;
    assign rst_lo_n_oe        = cur_q.drive;
    assign rst_hi_out         = cur_q.hi_level;
    assign rst_lo_n_out       = cur_q.lo_level;
    assign bus_enable         = cur_q.bus_en;
    assign data_ack_enable    = cur_q.data_ack_en;
    assign array_write_enable = cur_q.array_wr_en;
    assign prog_busy          = cur_q.busy;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_wdog_held_clear: assert property (cur_q.drive |-> cur_q.wdog_cnt == 32'h0)
        else $error("watchdog counted during reset");
    a_kick_clears_cnt: assert property (kick_edge |=> cur_q.wdog_cnt == 32'h0)
        else $error("kick edge did not clear watchdog");
    a_wdog_expiry: assert property (
        cur_q.state == ssw_pkg::SSW_RUN && wdog_expire && !kick_edge && !low_s
        |=> cur_q.state == ssw_pkg::SSW_TIMEOUT && rst_hi_oe && rst_lo_n_oe)
        else $error("watchdog expiry did not start reset");
    a_outputs_paired: assert property (
        rst_hi_oe == rst_lo_n_oe && rst_hi_out == rst_hi_oe && rst_lo_n_out == !rst_lo_n_oe)
        else $error("reset outputs disagree");
    a_trip_drives: assert property ($rose(low_s) |-> ##[1:2] (rst_hi_oe && !bus_enable))
        else $error("supply low not reflected on reset pins");
    a_timeout_release: assert property (
        cur_q.state == ssw_pkg::SSW_TIMEOUT && cur_q.rst_cnt == RST_CYC - 32'h1 && !low_s
        |=> !rst_hi_oe && !rst_lo_n_oe ##1 bus_enable || prog_busy)
        else $error("reset not released after timeout");
    a_timeout_holds: assert property (
        $fell(low_s) |-> rst_hi_oe [*8])
        else $error("reset released early after supply recovered");
    a_hi_edge_start: assert property (hi_rise && !low_s |=> rst_hi_oe && rst_lo_n_oe)
        else $error("rising manual reset ignored");
    a_lo_edge_start: assert property (lo_fall && !low_s |=> rst_hi_oe && rst_lo_n_oe)
        else $error("falling manual reset ignored");
    a_glitch_reject: assert property (
        $changed(cur_q.hi_flt) |-> $past(cur_q.hi_gcnt) == ssw_pkg::GLITCH_CYC)
        else $error("reset pin filter accepted a short pulse");
    a_wp_no_data_ack: assert property ($past(wp_s) |-> !data_ack_enable)
        else $error("data acknowledged under write protect");
    a_low_no_write: assert property (low_s |=> !array_write_enable)
        else $error("array write enabled with supply low");
    a_reset_no_ack: assert property (rst_hi_oe |-> !bus_enable && !array_write_enable)
        else $error("bus enabled during reset");
    a_prog_starts: assert property (
        write_stop && array_write_enable |=> prog_busy && !bus_enable)
        else $error("program cycle did not start");

endmodule : ssw_top

`default_nettype wire
